// ---- tks_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef TKS_REGS_SVH
`define TKS_REGS_SVH
`define TKS_ADDR_W          9
`define TKS_OFF_INT_EN      9'h00E
`define TKS_OFF_INT_FLAG    9'h01A
`define TKS_OFF_CNT_LO      9'h116
`define TKS_OFF_CNT_HI      9'h117
`define TKS_OFF_UPL_LO      9'h118
`define TKS_OFF_UPL_HI      9'h119
`define TKS_OFF_LOL_LO      9'h11A
`define TKS_OFF_LOL_HI      9'h11B
`define TKS_OFF_CLK_CFG     9'h11C
`define TKS_OFF_SENS_CFG    9'h11D
`define TKS_OFF_CONV_CTL    9'h11E
`define TKS_OFF_MOD_CTL     9'h11F
`define TKS_OFF_REF_LO      9'h194
`define TKS_OFF_REF_HI      9'h195
`define TKS_OFF_REF_CAP     9'h19A
`define TKS_OFF_AUTO_CTL    9'h19C
`define TKS_BIT_IRQ_EN      3
`define TKS_BIT_MAN_FLAG    4
`define TKS_BIT_SH_FLAG     3
`define TKS_BIT_START       4
`define TKS_BIT_DONE        0
`define TKS_BIT_DBL         6
`define TKS_BIT_PWR_OFF     4
`define TKS_BIT_HOP         0
`define TKS_BIT_HSENS       6
`define TKS_BIT_AUTO_EN     5
`define TKS_TFREQ_MSB       4
`define TKS_TFREQ_LSB       2
`define TKS_SPEED_MSB       1
`define TKS_HI_MSB          5
`define TKS_RATE_MSB        7
`define TKS_RATE_LSB        6
`define TKS_RST_MOD_CTL     8'h10
`define TKS_RST_CLK_CFG     8'h04
`define TKS_RST_ZERO        8'h00
// system clock 125 MHz; scan intervals in ms
`define TKS_CLK_KHZ         125000
`define TKS_IVL0_MS         20
`define TKS_IVL1_MS         25
`define TKS_IVL2_MS         40
`define TKS_IVL3_MS         80
// 3 us done-flag lag, rounded down to cycles
`define TKS_LAG_NS          3000
`define TKS_LAG_CYC         (`TKS_LAG_NS / 8)
`define TKS_TICK_KHZ        1
`endif

// ---- tks_pkg.sv ----
// types shared by the touch key scanner
package tks_pkg;
   typedef enum logic [1:0] {
      TKS_IDLE,
      TKS_CONV,
      TKS_LAG
   } tks_state_t;

   typedef struct packed {
      logic [13:0] count;
      logic        done;
   } tks_result_t;

   // per-conversion oscillator settings
   typedef struct packed {
      logic [7:0] ref_cap;
      logic [2:0] touch_freq;
      logic [1:0] osc_speed;
      logic       hop;
      logic       hsens;
      logic       dbl;
   } tks_osc_cfg_t;
endpackage : tks_pkg

// ---- tks_osc.sv ----
// behavioural stand-in for reference and touch oscillators as enables
`include "tks_regs.svh"
module tks_osc (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            arst_n,
   // control
   input  wire logic            run,
   input  tks_pkg::tks_osc_cfg_t cfg,
   input  wire logic            touch_in,
   // enables
   output logic                 ref_tick,
   output logic                 touch_tick
);
   typedef struct packed {
      logic [9:0] ref_acc;
      logic [9:0] tch_acc;
      logic [2:0] hop;
      logic       rt;
      logic       tt;
   } tks_osc_st_t;

   tks_osc_st_t s_q, s_d;
   logic [10:0] rsum, tsum;
   logic [9:0]  rstep, tstep;

   always_comb begin
      s_d = s_q;
      // capacitor trim and common speed set reference rate
      rstep = 10'(({2'b00, cfg.ref_cap} >> 2) + 10'd8)
              << cfg.osc_speed;
      // fixed touch rate unless hopping, then cycle through settings
      tstep = 10'({7'd0, (cfg.hop ? s_q.hop : cfg.touch_freq)} + 10'd8)
              << cfg.osc_speed;
      if (cfg.hsens && touch_in)
         tstep = tstep >> 2;
      else if (touch_in)
         tstep = tstep >> 1;
      rsum = {1'b0, s_q.ref_acc} + {1'b0, rstep};
      tsum = {1'b0, s_q.tch_acc} + {1'b0, tstep};
      s_d.rt = 1'b0;
      s_d.tt = 1'b0;
      if (run) begin
         s_d.ref_acc = rsum[9:0];
         s_d.tch_acc = tsum[9:0];
         s_d.rt      = rsum[10];
         s_d.tt      = tsum[10];
         if (tsum[10])
            s_d.hop = s_q.hop + 3'd1;
      end else begin
         s_d.ref_acc = '0;
         s_d.tch_acc = '0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign ref_tick   = s_q.rt;
   assign touch_tick = s_q.tt;
endmodule : tks_osc

// ---- tks_interval.sv ----
// auto-scan interval timer: millisecond divider and overflow pulse
`include "tks_regs.svh"
module tks_interval (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // control
   input  wire logic       enable,
   input  wire logic [1:0] rate,
   // overflow pulse
   output logic            overflow
);
   localparam logic [16:0] MS_CYC = 17'(`TKS_CLK_KHZ / `TKS_TICK_KHZ);

   typedef struct packed {
      logic [16:0] div;
      logic [6:0]  ms;
      logic        ovf;
   } tks_ivl_st_t;

   tks_ivl_st_t s_q, s_d;
   logic [6:0]  limit;

   always_comb begin
      s_d = s_q;
      s_d.ovf = 1'b0;
      case (rate)
         2'd0:    limit = 7'(`TKS_IVL0_MS);
         2'd1:    limit = 7'(`TKS_IVL1_MS);
         2'd2:    limit = 7'(`TKS_IVL2_MS);
         default: limit = 7'(`TKS_IVL3_MS);
      endcase
      if (!enable) begin
         s_d.div = '0;
         s_d.ms  = '0;
      end else if (s_q.div == MS_CYC - 17'd1) begin
         s_d.div = '0;
         if (s_q.ms >= limit - 7'd1) begin
            s_d.ms  = '0;
            s_d.ovf = 1'b1;
         end else begin
            s_d.ms = s_q.ms + 7'd1;
         end
      end else begin
         s_d.div = s_q.div + 17'd1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign overflow = s_q.ovf;
endmodule : tks_interval

// ---- tks_scanner.sv ----
// touch key scanner, module 0: registers, conversion and auto scan
//
// Summary of operation
// - reference oscillator timed conversion, tuned by capacitor
// - touch frequency fixed unless hop mode set
// - conversion lasts programmed reference cycle count
// - data counter gives 14-bit result split
// - start bit begins conversion, cleared at end
// - done flag low while converting, may lag
// - power-off falling edge sets module flag
// - flag pair encodes idle, manual, auto done
// - module flag set on manual done, cleared
// - shared flag set on manual done or low auto count, clears all
// - enable plus shared flag raises wake request
// - auto enable with power on gives hardware control
// - interval overflow starts channel zero scan
// - auto count below lower limit sets shared flag
// - only channel zero scans automatically
// - speed field scales both oscillators together
// - sensitivity bit selects higher sensitivity
// - rate-double bit doubles counting speed
// - power-off bit resets to one, module off
// - interval field picks 20/25/40/80 ms
// - reference compare is 14 bits, split high
// - eight-bit capacitor select tunes reference clock
//
// Implementation choice: the address-and-strobe port.
`include "tks_regs.svh"
module tks_scanner (
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   // register port
   input  wire logic [`TKS_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   // electrode sense (touched slows the touch oscillator)
   input  wire logic                   touch_in,
   // outputs
   output logic                        touch_irq,
   output logic                        module_on,
   output tks_pkg::tks_result_t        result
);
   typedef struct packed {
      tks_pkg::tks_state_t st;
      logic                auto_run;
      logic [13:0]         ref_cnt;
      logic [13:0]         data_cnt;
      logic [13:0]         res;
      logic [8:0]          lag;
      logic                done;
      logic                start;
      logic                pwr_off;
      logic                dbl;
      logic                hop;
      logic                irq_en;
      logic                man_flag;
      logic                sh_flag;
      logic [7:0]          upl_lo;
      logic [5:0]          upl_hi;
      logic [7:0]          lol_lo;
      logic [5:0]          lol_hi;
      logic [2:0]          tfreq;
      logic [1:0]          speed;
      logic                hsens;
      logic [7:0]          ref_lo;
      logic [5:0]          ref_hi;
      logic [7:0]          ref_cap;
      logic [1:0]          rate;
      logic                auto_en;
      logic [7:0]          rdata;
      logic                irq;
      logic                on;
   } tks_st_t;

   tks_st_t               s_q, s_d;
   tks_pkg::tks_osc_cfg_t ocfg;
   logic                  ref_tick;
   logic                  touch_tick;
   logic                  ivl_ovf;
   logic                  auto_mode;
   logic [13:0]           ref_target;
   logic [13:0]           limit;
   logic                  wr_flag;
   logic                  wr_conv;
   logic                  wr_mod;

   assign auto_mode  = s_q.auto_en && !s_q.pwr_off;
   assign ref_target = {s_q.ref_hi, s_q.ref_lo};
   assign limit      = {s_q.lol_hi, s_q.lol_lo};
   assign wr_flag    = reg_wr && (reg_addr == `TKS_OFF_INT_FLAG);
   assign wr_conv    = reg_wr && (reg_addr == `TKS_OFF_CONV_CTL);
   assign wr_mod     = reg_wr && (reg_addr == `TKS_OFF_MOD_CTL);

   always_comb begin
      ocfg.ref_cap    = s_q.ref_cap;
      ocfg.touch_freq = s_q.tfreq;
      ocfg.osc_speed  = s_q.speed;
      ocfg.hop        = s_q.hop;
      ocfg.hsens      = s_q.hsens;
      ocfg.dbl        = s_q.dbl;
   end

   tks_osc u_osc (
      .clock      (clock),
      .arst_n     (arst_n),
      .run        (s_q.st == tks_pkg::TKS_CONV),
      .cfg        (ocfg),
      .touch_in   (touch_in),
      .ref_tick   (ref_tick),
      .touch_tick (touch_tick)
   );

   tks_interval u_ivl (
      .clock    (clock),
      .arst_n   (arst_n),
      .enable   (auto_mode),
      .rate     (s_q.rate),
      .overflow (ivl_ovf)
   );

   always_comb begin
      s_d = s_q;
      // register writes
      if (reg_wr) begin
         if (reg_addr == `TKS_OFF_INT_EN)
            s_d.irq_en = reg_wdata[`TKS_BIT_IRQ_EN];
         else if (reg_addr == `TKS_OFF_UPL_LO)
            s_d.upl_lo = reg_wdata;
         else if (reg_addr == `TKS_OFF_UPL_HI)
            s_d.upl_hi = reg_wdata[`TKS_HI_MSB:0];
         else if (reg_addr == `TKS_OFF_LOL_LO)
            s_d.lol_lo = reg_wdata;
         else if (reg_addr == `TKS_OFF_LOL_HI)
            s_d.lol_hi = reg_wdata[`TKS_HI_MSB:0];
         else if (reg_addr == `TKS_OFF_CLK_CFG) begin
            s_d.tfreq = reg_wdata[`TKS_TFREQ_MSB:`TKS_TFREQ_LSB];
            s_d.speed = reg_wdata[`TKS_SPEED_MSB:0];
         end else if (reg_addr == `TKS_OFF_SENS_CFG)
            s_d.hsens = reg_wdata[`TKS_BIT_HSENS];
         else if (reg_addr == `TKS_OFF_MOD_CTL) begin
            s_d.dbl     = reg_wdata[`TKS_BIT_DBL];
            s_d.pwr_off = reg_wdata[`TKS_BIT_PWR_OFF];
            s_d.hop     = reg_wdata[`TKS_BIT_HOP];
         end else if (reg_addr == `TKS_OFF_REF_LO)
            s_d.ref_lo = reg_wdata;
         else if (reg_addr == `TKS_OFF_REF_HI)
            s_d.ref_hi = reg_wdata[`TKS_HI_MSB:0];
         else if (reg_addr == `TKS_OFF_REF_CAP)
            s_d.ref_cap = reg_wdata;
         else if (reg_addr == `TKS_OFF_AUTO_CTL) begin
            s_d.rate    = reg_wdata[`TKS_RATE_MSB:`TKS_RATE_LSB];
            s_d.auto_en = reg_wdata[`TKS_BIT_AUTO_EN];
         end
      end
      // flag clears by software first, hardware sets below win
      if (wr_flag && !reg_wdata[`TKS_BIT_MAN_FLAG])
         s_d.man_flag = 1'b0;
      if (wr_flag && !reg_wdata[`TKS_BIT_SH_FLAG]) begin
         s_d.sh_flag  = 1'b0;
         s_d.man_flag = 1'b0;
      end
      if (wr_conv && reg_wdata[`TKS_BIT_START]) begin
         s_d.man_flag = 1'b0;
         s_d.sh_flag  = 1'b0;
      end
      if (wr_conv && !reg_wdata[`TKS_BIT_START])
         s_d.start = 1'b0;
      // power-on edge raises module flag
      if (wr_mod && s_q.pwr_off && !reg_wdata[`TKS_BIT_PWR_OFF])
         s_d.man_flag = 1'b1;

      case (s_q.st)
         tks_pkg::TKS_IDLE: begin
            // auto scans own the module; manual starts are ignored
            if (auto_mode && ivl_ovf) begin
               s_d.st       = tks_pkg::TKS_CONV;
               s_d.auto_run = 1'b1;
               s_d.ref_cnt  = '0;
               s_d.data_cnt = '0;
               s_d.done     = 1'b0;
            end else if (!s_q.pwr_off && !auto_mode && wr_conv &&
                         reg_wdata[`TKS_BIT_START]) begin
               s_d.st       = tks_pkg::TKS_CONV;
               s_d.auto_run = 1'b0;
               s_d.start    = 1'b1;
               s_d.ref_cnt  = '0;
               s_d.data_cnt = '0;
               s_d.done     = 1'b0;
            end
         end
         tks_pkg::TKS_CONV: begin
            if (touch_tick)
               s_d.data_cnt = s_q.data_cnt +
                              (s_q.dbl ? 14'd2 : 14'd1);
            if (s_q.pwr_off)
               s_d.st = tks_pkg::TKS_IDLE;
            else if (s_q.ref_cnt >= ref_target) begin
               s_d.res = s_q.data_cnt;
               s_d.lag = '0;
               s_d.st  = tks_pkg::TKS_LAG;
            end else if (ref_tick)
               s_d.ref_cnt = s_q.ref_cnt + 14'd1;
         end
         tks_pkg::TKS_LAG: begin
            // done flag lags the conversion end
            if (s_q.lag >= 9'(`TKS_LAG_CYC - 1)) begin
               s_d.st    = tks_pkg::TKS_IDLE;
               s_d.done  = 1'b1;
               s_d.start = 1'b0;
               if (!s_q.auto_run) begin
                  s_d.man_flag = 1'b1;
                  s_d.sh_flag  = 1'b1;
               end else if (s_q.res < limit)
                  s_d.sh_flag = 1'b1;
               s_d.auto_run = 1'b0;
            end else
               s_d.lag = s_q.lag + 9'd1;
         end
         default: s_d.st = tks_pkg::TKS_IDLE;
      endcase

      // read data one cycle after strobe; unmapped reads zero
      s_d.rdata = `TKS_RST_ZERO;
      if (reg_rd) begin
         if (reg_addr == `TKS_OFF_INT_EN)
            s_d.rdata = {4'd0, s_q.irq_en, 3'd0};
         else if (reg_addr == `TKS_OFF_INT_FLAG)
            s_d.rdata = {3'd0, s_q.man_flag, s_q.sh_flag, 3'd0};
         else if (reg_addr == `TKS_OFF_CNT_LO)
            s_d.rdata = s_q.res[7:0];
         else if (reg_addr == `TKS_OFF_CNT_HI)
            s_d.rdata = {2'd0, s_q.res[13:8]};
         else if (reg_addr == `TKS_OFF_UPL_LO)
            s_d.rdata = s_q.upl_lo;
         else if (reg_addr == `TKS_OFF_UPL_HI)
            s_d.rdata = {2'd0, s_q.upl_hi};
         else if (reg_addr == `TKS_OFF_LOL_LO)
            s_d.rdata = s_q.lol_lo;
         else if (reg_addr == `TKS_OFF_LOL_HI)
            s_d.rdata = {2'd0, s_q.lol_hi};
         else if (reg_addr == `TKS_OFF_CLK_CFG)
            s_d.rdata = {3'd0, s_q.tfreq, s_q.speed};
         else if (reg_addr == `TKS_OFF_SENS_CFG)
            s_d.rdata = {1'b0, s_q.hsens, 6'd0};
         else if (reg_addr == `TKS_OFF_CONV_CTL)
            s_d.rdata = {3'd0, s_q.start, 3'd0, s_q.done};
         else if (reg_addr == `TKS_OFF_MOD_CTL)
            s_d.rdata = {1'b0, s_q.dbl, 1'b0, s_q.pwr_off, 3'd0, s_q.hop};
         else if (reg_addr == `TKS_OFF_REF_LO)
            s_d.rdata = s_q.ref_lo;
         else if (reg_addr == `TKS_OFF_REF_HI)
            s_d.rdata = {2'd0, s_q.ref_hi};
         else if (reg_addr == `TKS_OFF_REF_CAP)
            s_d.rdata = s_q.ref_cap;
         else if (reg_addr == `TKS_OFF_AUTO_CTL)
            s_d.rdata = {s_q.rate, s_q.auto_en, 5'd0};
      end
      s_d.irq = s_d.irq_en && s_d.sh_flag;
      s_d.on  = !s_d.pwr_off;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q         <= '0;
         s_q.st      <= tks_pkg::TKS_IDLE;
         s_q.pwr_off <= 1'(`TKS_RST_MOD_CTL >> `TKS_BIT_PWR_OFF);
         s_q.tfreq   <= 3'(`TKS_RST_CLK_CFG >> `TKS_TFREQ_LSB);
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata    = s_q.rdata;
   assign touch_irq    = s_q.irq;
   assign module_on    = s_q.on;
   assign result       = {s_q.res, s_q.done};
endmodule : tks_scanner

// ---- tks_scanner_props.sv ----
// port-level assertions for the touch key scanner
module tks_scanner_props (
   // clock and reset
   input wire logic                 clock,
   input wire logic                 arst_n,
   // register port
   input wire logic [8:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   // sense and outputs
   input wire logic                 touch_in,
   input wire logic                 touch_irq,
   input wire logic                 module_on,
   input wire tks_pkg::tks_result_t result
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LAG = 375;
   logic       auto_q;
   logic       ien_q;
   logic [9:0] lag_q;
   logic       start_wr;
   logic       pwr_wr;
   assign start_wr = reg_wr && reg_addr == 9'h11E && reg_wdata[4];
   assign pwr_wr   = reg_wr && reg_addr == 9'h11F;
   // shadows of write-only knowledge the ports do not show
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         auto_q <= 1'b0;
         ien_q  <= 1'b0;
         lag_q  <= 10'h000;
      end else begin
         if (reg_wr && reg_addr == 9'h19C) begin
            auto_q <= reg_wdata[5];
         end
         if (reg_wr && reg_addr == 9'h00E) begin
            ien_q <= reg_wdata[3];
         end
         if (start_wr) begin
            lag_q <= 10'h000;
         end else if (lag_q != 10'h3FF) begin
            lag_q <= lag_q + 10'h001;
         end
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   chk_on_write: assert property (
      pwr_wr && !reg_wdata[4] |=> module_on) else $error("module not on");
   chk_off_write: assert property (
      pwr_wr && reg_wdata[4] |=> !module_on) else $error("module not off");
   chk_on_cause: assert property (
      $rose(module_on) |-> $past(pwr_wr && !reg_wdata[4]))
      else $error("module on without write");
   chk_lo_read: assert property (
      reg_rd && reg_addr == 9'h116 |=> reg_rdata == $past(result.count[7:0]))
      else $error("count low read wrong");
   chk_hi_read: assert property (
      reg_rd && reg_addr == 9'h117
      |=> reg_rdata == {2'b00, $past(result.count[13:8])})
      else $error("count high read wrong");
   chk_done_cause: assert property (
      $fell(result.done) && !auto_q |-> $past(start_wr) || $past(start_wr, 2))
      else $error("done fell without start");
   chk_done_lag: assert property (
      $rose(result.done) && !auto_q |-> lag_q >= LAG)
      else $error("done rose too early");
   chk_irq_enable: assert property (
      touch_irq |-> ien_q || $past(ien_q)) else $error("irq while disabled");
   chk_start_clears: assert property (
      start_wr && !auto_q |-> ##2 !touch_irq)
      else $error("irq kept after start");
   chk_flag_clear: assert property (
      reg_wr && reg_addr == 9'h01A && !reg_wdata[3] && !auto_q
      |-> ##2 !touch_irq) else $error("irq kept after flag clear");
endmodule : tks_scanner_props

bind tks_scanner tks_scanner_props i_tks_scanner_props (
   .clock     (clock),
   .arst_n    (arst_n),
   .reg_addr  (reg_addr),
   .reg_wdata (reg_wdata),
   .reg_wr    (reg_wr),
   .reg_rd    (reg_rd),
   .reg_rdata (reg_rdata),
   .touch_in  (touch_in),
   .touch_irq (touch_irq),
   .module_on (module_on),
   .result    (result)
);

// ---- tks_pad_model.sv ----
// electrode pad model: finger presence reaches the sense input late
module tks_pad_model #(
   parameter int SETTLE = 4
) (
   // clock
   input  wire logic clock,
   // stimulus
   input  wire logic finger,
   // sense output
   output logic      touch_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [SETTLE-1:0] pipe_q = '0;
   // a real pad charges slowly, so contact is never seen at once
   always @(posedge clock) begin
      pipe_q <= {pipe_q[SETTLE-2:0], finger};
   end
   assign touch_in = pipe_q[SETTLE-1];
endmodule : tks_pad_model

// ---- capacitive_touch_key_scanner_tb.sv ----
// self-checking bench for the touch key scanner
module capacitive_touch_key_scanner_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clock;
   logic                 arst_n;
   logic [8:0]           reg_addr;
   logic [7:0]           reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   logic [7:0]           reg_rdata;
   logic                 touch_in;
   logic                 touch_irq;
   logic                 module_on;
   tks_pkg::tks_result_t result;
   logic                 finger;
   int                   errors;
   int                   n_tests;
   logic [13:0]          c0;
   logic [13:0]          c1;
   logic [13:0]          c2;
   logic [8:0] t_a [9] = '{9'h118, 9'h119, 9'h11A, 9'h11B, 9'h19A,
                           9'h195, 9'h194, 9'h11D, 9'h11C};
   logic [7:0] t_v [9] = '{8'hA5, 8'h2A, 8'h5A, 8'h15, 8'h4D,
                           8'h00, 8'h10, 8'h40, 8'h06};
   logic [7:0] t_m [9] = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF,
                           8'h3F, 8'hFF, 8'h40, 8'h1F};

   tks_scanner i_tks_scanner (
      .clock     (clock),
      .arst_n    (arst_n),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .touch_in  (touch_in),
      .touch_irq (touch_irq),
      .module_on (module_on),
      .result    (result)
   );
   tks_pad_model i_tks_pad_model (
      .clock    (clock),
      .finger   (finger),
      .touch_in (touch_in)
   );

   always #4 clock = ~clock;

   task automatic end_of_test;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] v, input logic [7:0] m);
      n_tests++;
      if ((v & m) !== (e & m)) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e & m, v & m);
      end
   endtask : chk8

   task automatic chk1(input string nm, input logic e, input logic v);
      n_tests++;
      if (v !== e) begin
         errors++;
         $display("MISMATCH %s exp %b got %b", nm, e, v);
      end
   endtask : chk1

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      // let the edge's updates settle before the caller looks
      #1;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic rchk(input logic [8:0] a, input logic [7:0] e,
                       input logic [7:0] m);
      logic [7:0] v;
      rd(a, v);
      chk8($sformatf("reg_%h", a), e, v, m);
   endtask : rchk

   // manual conversion; flags are left set for the caller
   task automatic conv(input logic exp_irq, output logic [13:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      int         k;
      wr(9'h11E, 8'h10);
      rchk(9'h11E, 8'h10, 8'h11);
      for (k = 0; k < 30000 && result.done !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      chk1("done_wait", 1'b1, result.done);
      rchk(9'h11E, 8'h01, 8'h11);
      rchk(9'h01A, 8'h18, 8'h18);
      chk1("touch_irq", exp_irq, touch_irq);
      rd(9'h116, lo);
      rd(9'h117, hi);
      chk8("count_hi_pad", 8'h00, hi, 8'hC0);
      c = {hi[5:0], lo};
   endtask : conv

   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      end_of_test();
   end

   initial begin
      clock     = 1'b0;
      arst_n    = 1'b0;
      reg_addr  = 9'h000;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      finger    = 1'b0;
      errors    = 0;
      n_tests   = 0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      rchk(9'h00E, 8'h00, 8'hFF);
      rchk(9'h01A, 8'h00, 8'hFF);
      rchk(9'h11F, 8'h10, 8'h51);
      rchk(9'h194, 8'h00, 8'hFF);
      rchk(9'h19A, 8'h00, 8'hFF);
      rchk(9'h11C, 8'h04, 8'h1F);
      chk1("module_on", 1'b0, module_on);
      wr(9'h100, 8'h5A);
      rchk(9'h100, 8'h00, 8'hFF);
      for (int i = 0; i < 9; i++) begin
         wr(t_a[i], t_v[i]);
         rchk(t_a[i], t_v[i], t_m[i]);
      end
      // power-on edge raises the module flag
      wr(9'h11F, 8'h00);
      rchk(9'h01A, 8'h10, 8'h18);
      chk1("module_on", 1'b1, module_on);
      wr(9'h01A, 8'hEF);
      rchk(9'h01A, 8'h00, 8'h18);
      wr(9'h00E, 8'h08);
      rchk(9'h00E, 8'h08, 8'h08);
      conv(1'b1, c0);
      wr(9'h01A, 8'hF7);
      rchk(9'h01A, 8'h00, 8'h18);
      chk1("irq_cleared", 1'b0, touch_irq);
      finger <= 1'b1;
      repeat (20) @(posedge clock);
      conv(1'b1, c1);
      chk1("touch_lowers", 1'b1, c1 < c0);
      wr(9'h01A, 8'hEF);
      rchk(9'h01A, 8'h08, 8'h18);
      wr(9'h01A, 8'hF7);
      finger <= 1'b0;
      wr(9'h00E, 8'h00);
      wr(9'h11F, 8'h40);
      conv(1'b0, c2);
      chk1("rate_double", 1'b1, c2 > c0);
      // auto mode owns the module, so a manual start is refused
      wr(9'h19C, 8'h60);
      rchk(9'h19C, 8'h60, 8'hE0);
      wr(9'h11E, 8'h10);
      rchk(9'h11E, 8'h00, 8'h10);
      wr(9'h19C, 8'h00);
      // start while off is refused; flags, cleared by the refused auto-mode start, stay clear
      wr(9'h11F, 8'h10);
      chk1("module_off", 1'b0, module_on);
      wr(9'h11E, 8'h10);
      rchk(9'h11E, 8'h00, 8'h10);
      rchk(9'h01A, 8'h00, 8'h18);
      rchk(9'h118, 8'hA5, 8'hFF);
      wr(9'h11F, 8'h00);
      wr(9'h11E, 8'h10);
      wr(9'h11E, 8'h00);
      rchk(9'h11E, 8'h00, 8'h10);
      end_of_test();
   end
endmodule : capacitive_touch_key_scanner_tb
